// ===== hw/peripheral_input_pin_router.sv
/*
  Peripheral pin router with an AHB-Lite register slave. Each peripheral input
  has its own six-bit pin selection register; each pin has its own output
  source selection register. Pin levels are readable, and an analog select
  bit per pin gates that pin's digital input buffer.
  Assumes pins arrive asynchronously and peripheral outputs run on hclk.
*/
`timescale 1ns/1ps
module peripheral_input_pin_router #(
  parameter int NUM_IN   = pin_router_pkg::NUM_IN,
  parameter int NUM_PINS = pin_router_pkg::NUM_PINS
) (
  // Clock and reset.
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  // AHB-Lite slave.
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic                                        hreadyout,
  output logic                                        hresp,
  output logic      [31:0]                            hrdata,
  // Device pins.
  input  wire logic [NUM_PINS-1:0]                    pin_in,
  output logic      [NUM_PINS-1:0]                    pin_out,
  output logic      [NUM_PINS-1:0]                    analog_select_bit,
  // Peripheral side.
  input  wire logic [pin_router_pkg::NUM_OUT_SRC-1:0] periph_out,
  output logic      [NUM_IN-1:0]                      periph_in
);

  // Bus state.
  pin_router_pkg::bus_phase_type phase_r;     // Current data phase.
  pin_router_pkg::ahb_addr_type  addr_r;      // Captured address phase.
  logic                          accept;      // A word transfer is taken this edge.
  logic                          wr_en;       // Write strobe at the end of a write data phase.
  logic [31:0]                   read_word;   // Word that the addressed register reads.

  // Register state.
  logic [NUM_PINS-1:0]           latch_r;     // Pin output latch, used by source code 0.
  logic [NUM_PINS-1:0]           analog_r;    // Analog select, one bit per pin.
  logic [NUM_IN-1:0][5:0]        in_sel_r;    // Input pin selection codes.
  logic [NUM_PINS-1:0][4:0]      out_sel_r;   // Output source codes.

  // Pin side.
  logic [NUM_PINS-1:0]           pin_sync;    // Synchronised pin levels.
  logic [NUM_PINS-1:0]           pin_digital; // Levels behind the digital input buffers.

  // The slave never signals an error.
  assign hresp = pin_router_pkg::HRESP_OKAY;

  // Reads take one wait state so that hrdata comes from a flop and sees any write just before.
  assign hreadyout = (phase_r != pin_router_pkg::PH_READ_WAIT);

  // A transfer is taken only for a selected, non-sequential, whole-word access.
  assign accept = hsel && hready && (htrans == pin_router_pkg::HTRANS_NONSEQ) &&
                  (hsize == pin_router_pkg::HSIZE_WORD);

  // Registers change at the edge that ends the write data phase.
  assign wr_en = (phase_r == pin_router_pkg::PH_WRITE) && addr_r.write;

  // Bus phase sequencing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= pin_router_pkg::PH_IDLE;
    end else begin
      case (phase_r)
        pin_router_pkg::PH_READ_WAIT: begin
          // The wait state always lasts exactly one cycle.
          phase_r <= pin_router_pkg::PH_READ_DONE;
        end
        pin_router_pkg::PH_IDLE,
        pin_router_pkg::PH_WRITE,
        pin_router_pkg::PH_READ_DONE: begin
          if (accept && hwrite) begin
            phase_r <= pin_router_pkg::PH_WRITE;
          end else if (accept) begin
            phase_r <= pin_router_pkg::PH_READ_WAIT;
          end else begin
            phase_r <= pin_router_pkg::PH_IDLE;
          end
        end
        default: begin
          phase_r <= pin_router_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Address phase capture; only the low window bits are decoded, so the map repeats.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= '0;
    end else if (accept) begin
      addr_r.offset <= haddr[pin_router_pkg::ADDR_W-1:0];
      addr_r.write  <= hwrite;
    end
  end

  // Pins cross into hclk through two flops before any routing logic sees them.
  level_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // A set analog select bit turns the digital input buffer off, so the pin reads low.
  assign pin_digital = pin_sync & ~analog_r;

  // Output latch register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= pin_router_pkg::LATCH_RESET;
    end else if (wr_en && (addr_r.offset == pin_router_pkg::ADDR_LATCH)) begin
      latch_r <= hwdata[NUM_PINS-1:0];
    end
  end

  // Analog select register; analog signals themselves never pass through the router.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_r <= pin_router_pkg::ANALOG_RESET;
    end else if (wr_en && (addr_r.offset == pin_router_pkg::ADDR_ANALOG)) begin
      analog_r <= hwdata[NUM_PINS-1:0];
    end
  end

  assign analog_select_bit = analog_r;

  // One selection register and one multiplexer per peripheral input.
  for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_input
    localparam logic [11:0] SEL_ADDR = pin_router_pkg::ADDR_IN_SEL_BASE + 12'(gi * 4);

    // Each register loads its own power-on code and is written only at its own word.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        in_sel_r[gi] <= pin_router_pkg::IN_SEL_RESET[gi];
      end else if (wr_en && (addr_r.offset == SEL_ADDR)) begin
        in_sel_r[gi] <= hwdata[pin_router_pkg::SEL_W-1:0];
      end
    end

    // The same decoder serves every input, so a code means the same pin everywhere.
    input_pin_mux #(
      .ALLOWED_PORTS (pin_router_pkg::IN_ALLOWED_PORTS[gi])
    ) u_mux (
      .sel_code      (in_sel_r[gi]),
      .pin_level     (pin_digital),
      .routed        (periph_in[gi])
    );
  end

  // One output source register and selector per pin, untouched by input selections.
  for (genvar gp = 0; gp < NUM_PINS; gp++) begin : g_pin
    localparam logic [11:0] OUT_ADDR = pin_router_pkg::ADDR_OUT_SEL_BASE + 12'(gp * 4);

    // Per-pin source register, e.g. code 0x09 on pin C6 sends serial port 1 transmit out.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        out_sel_r[gp] <= pin_router_pkg::OUT_SEL_RESET;
      end else if (wr_en && (addr_r.offset == OUT_ADDR)) begin
        out_sel_r[gp] <= hwdata[pin_router_pkg::OUT_SEL_W-1:0];
      end
    end

    // Code 0 drives the latch; codes beyond the last source fall back to the latch too.
    always_comb begin
      if (out_sel_r[gp] == pin_router_pkg::OUT_SRC_LATCH) begin
        pin_out[gp] = latch_r[gp];
      end else if (out_sel_r[gp] < 5'(pin_router_pkg::NUM_OUT_SRC)) begin
        pin_out[gp] = periph_out[out_sel_r[gp]];
      end else begin
        pin_out[gp] = latch_r[gp];
      end
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb begin
    read_word = 32'h00000000;
    if (addr_r.offset == pin_router_pkg::ADDR_PORT_LEVEL) begin
      // Pin levels, independent of any input selection.
      read_word[NUM_PINS-1:0] = pin_digital;
    end else if (addr_r.offset == pin_router_pkg::ADDR_LATCH) begin
      read_word[NUM_PINS-1:0] = latch_r;
    end else if (addr_r.offset == pin_router_pkg::ADDR_ANALOG) begin
      read_word[NUM_PINS-1:0] = analog_r;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (addr_r.offset == pin_router_pkg::ADDR_IN_SEL_BASE + 12'(i * 4)) begin
          read_word[pin_router_pkg::SEL_W-1:0] = in_sel_r[i];
        end
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        if (addr_r.offset == pin_router_pkg::ADDR_OUT_SEL_BASE + 12'(p * 4)) begin
          read_word[pin_router_pkg::OUT_SEL_W-1:0] = out_sel_r[p];
        end
      end
    end
  end

  // Read data is registered in the wait state and held until the next read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (phase_r == pin_router_pkg::PH_READ_WAIT) begin
      hrdata <= read_word;
    end
  end

endmodule : peripheral_input_pin_router

// ===== hw/pin_router_pkg.sv
/*
  Shared constants and types for the peripheral input pin router: the register
  map, code layouts, reset values and the per-input allowed-port masks.
  Assumes a 28-pin package (ports A, B, C and the single input pin E3).
*/
package pin_router_pkg;

  // Sizes of the routing fabric.
  localparam int NUM_IN      = 30;   // Peripheral inputs, each with its own selection register.
  localparam int NUM_PINS    = 25;   // A0..A7, B0..B7, C0..C7 and E3.
  localparam int SEL_W       = 6;    // Width of an input selection code.
  localparam int OUT_SEL_W   = 5;    // Width of an output source code.
  localparam int NUM_OUT_SRC = 24;   // Output source codes 0x00..0x17.
  localparam int PORT_W      = 3;    // Port field, upper bits of a code.
  localparam int BIT_W       = 3;    // Pin number field, lower bits of a code.

  // Port field values and field positions of an input selection code.
  localparam logic [2:0] PORT_A   = 3'h0;
  localparam logic [2:0] PORT_B   = 3'h1;
  localparam logic [2:0] PORT_C   = 3'h2;
  localparam logic [2:0] PORT_E   = 3'h4;
  localparam int         PORT_LSB = 3;
  localparam logic [2:0] E_PIN_BIT    = 3'h3;   // Only E3 exists on port E.
  localparam logic [4:0] PIN_E3_INDEX = 5'h18;  // Position of E3 in the pin vectors.

  // Example codes that software uses.
  localparam logic [5:0] CODE_PIN_C7         = 6'h17;
  localparam logic [5:0] CODE_PIN_E3         = 6'h23;
  localparam logic [4:0] OUT_SRC_LATCH       = 5'h00;
  localparam logic [4:0] OUT_SRC_SERIAL1_TX  = 5'h09;
  localparam int         PIN_C6_INDEX        = 22;

  // Indices of some named peripheral inputs.
  localparam int IN_EXT_INT0        = 0;
  localparam int IN_SERIAL1_RX      = 20;
  localparam int IN_SYNC_SERIAL1_CK = 24;

  // Register byte offsets within the slave window.
  localparam logic [11:0] ADDR_PORT_LEVEL  = 12'h000;
  localparam logic [11:0] ADDR_LATCH       = 12'h004;
  localparam logic [11:0] ADDR_ANALOG      = 12'h008;
  localparam logic [11:0] ADDR_IN_SEL_BASE = 12'h100;
  localparam logic [11:0] ADDR_OUT_SEL_BASE = 12'h200;
  localparam int          ADDR_W           = 12;

  // Reset values of the plain registers.
  localparam logic [24:0] LATCH_RESET   = 25'h0000000;
  localparam logic [24:0] ANALOG_RESET  = 25'h1FFFFFF;
  localparam logic [4:0]  OUT_SEL_RESET = 5'h00;

  // Power-on codes of the input selection registers, index 29 first.
  localparam logic [NUM_IN-1:0][5:0] IN_SEL_RESET = {
    6'h08, 6'h0A, 6'h09, 6'h05, 6'h14, 6'h13, 6'h0E, 6'h0F, 6'h16, 6'h17,
    6'h05, 6'h04, 6'h03, 6'h08, 6'h11, 6'h12, 6'h0C, 6'h0F, 6'h15, 6'h13,
    6'h0C, 6'h12, 6'h10, 6'h10, 6'h0D, 6'h10, 6'h04, 6'h0A, 6'h09, 6'h08};

  // Allowed ports per input, bit n set when port code n may feed it; index 29 first.
  localparam logic [NUM_IN-1:0][7:0] IN_ALLOWED_PORTS = {
    8'h06, 8'h06, 8'h06, 8'h05, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h06,
    8'h05, 8'h05, 8'h05, 8'h06, 8'h06, 8'h06, 8'h06, 8'h02, 8'h06, 8'h05,
    8'h02, 8'h05, 8'h05, 8'h06, 8'h06, 8'h05, 8'h03, 8'h03, 8'h03, 8'h03};

  // AHB-Lite encodings that the slave checks.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Address phase as captured for the following data phase.
  typedef struct packed {
    logic [11:0] offset;  // Byte offset within the slave window.
    logic        write;   // High for a write transfer.
  } ahb_addr_type;

  // Bus phase of the slave.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ_WAIT,
    PH_READ_DONE
  } bus_phase_type;

endpackage : pin_router_pkg

// ===== hw/level_sync.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow asynchronous level; no bus coherence is kept.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 25
) (
  // Clock and reset.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second stage.

  // Both stages clear at reset; the first stage feeds nothing but the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync

// ===== hw/input_pin_mux.sv
/*
  One peripheral input's pin multiplexer: decodes a six-bit selection code
  into a pin and forwards that pin's digital level.
  Assumes the pin levels are already synchronised and analog-gated.
*/
`timescale 1ns/1ps
module input_pin_mux #(
  parameter logic [7:0] ALLOWED_PORTS = 8'h03
) (
  // Selection code and pin levels.
  input  wire logic [5:0]  sel_code,
  input  wire logic [24:0] pin_level,
  // Level routed to the peripheral.
  output logic             routed
);

  logic [2:0] port_field;  // Port named by the code.
  logic [2:0] bit_field;   // Pin number named by the code.
  logic       supported;   // Code names a pin that this input may use.
  logic [4:0] pin_index;   // Position of the pin in the pin vector.

  assign port_field = sel_code[5:pin_router_pkg::PORT_LSB];
  assign bit_field  = sel_code[pin_router_pkg::PORT_LSB-1:0];

  // Decode port and pin; a code outside the allowed set drives a quiet low.
  always_comb begin
    supported = ALLOWED_PORTS[port_field];
    pin_index = {port_field[1:0], bit_field};
    if (port_field == pin_router_pkg::PORT_E) begin
      // Port E carries only its pin 3.
      pin_index = pin_router_pkg::PIN_E3_INDEX;
      supported = supported && (bit_field == pin_router_pkg::E_PIN_BIT);
    end else if (port_field > pin_router_pkg::PORT_C) begin
      supported = 1'b0;
    end
  end

  // Reading the shared level leaves it untouched, so any number of inputs may pick one pin.
  assign routed = supported ? pin_level[pin_index] : 1'b0;

endmodule : input_pin_mux

// ===== bench/peripheral_input_pin_router_assertions.sv
/*
  Port checker for the peripheral input pin router: bus timing and routing stability.
  Assumes a single hclk domain and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module peripheral_input_pin_router_assertions #(
  parameter int NUM_IN   = 30,
  parameter int NUM_PINS = 25
) (
  // Clock and reset.
  input wire logic                                   hclk,
  input wire logic                                   hresetn,
  // Bus.
  input wire logic                                   hsel,
  input wire logic [31:0]                            haddr,
  input wire logic [1:0]                             htrans,
  input wire logic                                   hwrite,
  input wire logic [2:0]                             hsize,
  input wire logic [31:0]                            hwdata,
  input wire logic                                   hready,
  input wire logic                                   hreadyout,
  input wire logic                                   hresp,
  input wire logic [31:0]                            hrdata,
  // Pins and peripherals.
  input wire logic [NUM_PINS-1:0]                    pin_in,
  input wire logic [NUM_PINS-1:0]                    pin_out,
  input wire logic [NUM_PINS-1:0]                    analog_select_bit,
  input wire logic [pin_router_pkg::NUM_OUT_SRC-1:0] periph_out,
  input wire logic [NUM_IN-1:0]                      periph_in
);
  logic taken;     // An address phase is accepted this cycle.
  logic wr_dp_r;   // A write data phase is in progress.
  logic any_wr_r;  // Some write was accepted since reset.
  assign taken = hsel && hready && htrans == pin_router_pkg::HTRANS_NONSEQ && hsize == pin_router_pkg::HSIZE_WORD;
  // Registers only move at the end of a write data phase, so routing is judged around them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_r  <= 1'h0;
      any_wr_r <= 1'h0;
    end else begin
      if (hready) wr_dp_r <= taken && hwrite;
      if (taken && hwrite) any_wr_r <= 1'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("Write data phase was stalled.");
  a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait was not exactly one cycle.");
  a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("Read data moved outside a read.");
  a_narrow_ignored: assert property (hsel && hready && htrans == pin_router_pkg::HTRANS_NONSEQ
    && hsize != pin_router_pkg::HSIZE_WORD |=> hreadyout) else $error("Narrow transfer caused a wait.");
  a_analog_masks: assert property ((&analog_select_bit) [*3] |-> periph_in == '0)
    else $error("Analog pin reached a peripheral.");
  a_pin_out_reset: assert property (!any_wr_r |-> pin_out == '0)
    else $error("Pin output not at latch reset level.");
  a_routing_still: assert property ((!wr_dp_r && $stable(pin_in)) [*4] |-> $stable(periph_in))
    else $error("Peripheral input moved without cause.");
  a_outputs_still: assert property ((!wr_dp_r && $stable(periph_out)) [*2] |-> $stable(pin_out))
    else $error("Pin output moved without cause.");
  c_read: cover property (taken && !hwrite);
  c_write: cover property (taken && hwrite);
  c_routed: cover property (periph_in != '0);
endmodule : peripheral_input_pin_router_assertions

bind peripheral_input_pin_router peripheral_input_pin_router_assertions #(.NUM_IN(NUM_IN), .NUM_PINS(NUM_PINS))
  i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .pin_in, .pin_out, .analog_select_bit, .periph_out, .periph_in);

// ===== bench/pin_periph_model.sv
/*
  Model of the device pins and on-chip peripherals around the router.
  Assumes the bench commands the levels; pins move off the clock edge.
*/
`timescale 1ns/1ps
module pin_periph_model (
  // Clock of the peripherals.
  input  wire logic        hclk,
  // Levels commanded by the bench.
  input  wire logic [24:0] pin_cmd,
  input  wire logic [23:0] src_cmd,
  // Levels seen by the router.
  output logic      [24:0] pin_in,
  output logic      [23:0] periph_out
);
  // Both start low so the design sees no unknown at time zero.
  initial begin
    pin_in     = 25'h0;
    periph_out = 24'h0;
  end
  // Pins are asynchronous and digital: they settle 7 ns after the command, never on an edge.
  always @(pin_cmd) pin_in <= #7 pin_cmd;
  // Peripheral outputs run on the bus clock, so they lag the command by one edge.
  always @(posedge hclk) periph_out <= src_cmd;
endmodule : pin_periph_model

// ===== bench/peripheral_input_pin_router_tb.sv
/*
  Self-checking bench for the peripheral input pin router: a table of routes, then
  sharing, timing, output, bus and reset cases.
  Assumes the checker is bound to the design and the pin model drives the pins.
*/
`timescale 1ns/1ps
module peripheral_input_pin_router_tb;
  // One route: input index, code, pin to raise, whether it should arrive.
  typedef struct packed {
    logic [4:0] idx;
    logic [5:0] code;
    logic [4:0] pin;
    logic       routed;
  } route_type;
  logic        hclk    = 1'h0;   // 20 MHz bus clock.
  logic        hresetn = 1'h0;   // Active-low reset.
  logic        hsel    = 1'h0;   // Bus inputs.
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'h0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        hreadyout;        // Also the bus hready.
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;               // Last read word.
  logic [24:0] pin_in, pin_out, analog_select_bit;
  logic [24:0] pin_cmd = 25'h0;  // Pin levels asked of the model.
  logic [23:0] periph_out;
  logic [23:0] src_cmd = 24'h0;  // Peripheral output levels asked of the model.
  logic [29:0] periph_in;
  int          num_errors = 0;
  int          cmp_count  = 0;
  // Ordinary routes; each row gives its input, code, pin and whether the level should arrive.
  route_type   rows [10] = '{
    '{5'h14, 6'h17, 5'h17, 1'h1},
    '{5'h00, 6'h08, 5'h08, 1'h1},
    '{5'h00, 6'h17, 5'h17, 1'h0},
    '{5'h00, 6'h05, 5'h05, 1'h1},
    '{5'h18, 6'h23, 5'h18, 1'h0},
    '{5'h01, 6'h3F, 5'h00, 1'h0},
    '{5'h18, 6'h0A, 5'h0A, 1'h1},
    '{5'h04, 6'h12, 5'h12, 1'h1},
    '{5'h04, 6'h0A, 5'h0A, 1'h0},
    '{5'h00, 6'h19, 5'h01, 1'h0}};
  peripheral_input_pin_router i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_in, .pin_out, .analog_select_bit, .periph_out, .periph_in);
  pin_periph_model i_pins (.hclk, .pin_cmd, .src_cmd, .pin_in, .periph_out);
  always #25 hclk = ~hclk;
  // Compare one value and count it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // One single AHB-Lite transfer; entered just after a rising edge, returns on the data-phase edge.
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rdv,
                     input logic [2:0] sz = 3'h2);
    hsel   <= 1'h1;
    haddr  <= {20'h0, addr};
    htrans <= pin_router_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rdv = hrdata;
  endtask : bus
  // Long enough for a pin change to cross both synchroniser flops.
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask : settle
  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // A hang ends the run as a failure.
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h1, pin_router_pkg::ADDR_ANALOG, 32'h0, rd);
    // Each route is tried with its pin alone high, then alone low, so a wrong pin shows.
    foreach (rows[i]) begin
      bus(1'h1, 12'h100 + {5'h0, rows[i].idx, 2'h0}, {26'h0, rows[i].code}, rd);
      pin_cmd <= 25'h1 << rows[i].pin;
      settle();
      check({31'h0, periph_in[rows[i].idx]}, {31'h0, rows[i].routed}, "route high");
      pin_cmd <= ~(25'h1 << rows[i].pin);
      settle();
      check({31'h0, periph_in[rows[i].idx]}, 32'h0, "route low");
    end
    // Two inputs on one pin both see it.
    bus(1'h1, 12'h154, 32'h17, rd);
    pin_cmd <= 25'h800000;
    settle();
    check({30'h0, periph_in[21:20]}, 32'h3, "shared pin");
    // A new selection shows in the cycle right after the data-phase edge.
    pin_cmd <= 25'h100;
    settle();
    check({31'h0, periph_in[20]}, 32'h0, "before select");
    bus(1'h1, 12'h150, 32'h08, rd);
    #1 check({31'h0, periph_in[20]}, 32'h1, "after select");
    @(posedge hclk);
    // Port read returns the pin levels.
    pin_cmd <= 25'h1A5A5A5;
    settle();
    bus(1'h0, pin_router_pkg::ADDR_PORT_LEVEL, 32'h0, rd);
    check(rd, 32'h1A5A5A5, "port level");
    check({31'h0, hresp}, {31'h0, pin_router_pkg::HRESP_OKAY}, "okay response");
    check({31'h0, periph_in[20]}, 32'h1, "digital pin routed");
    // Turning pin B0 analog must cut it off from the input that selects it.
    bus(1'h1, pin_router_pkg::ADDR_ANALOG, 32'h100, rd);
    @(posedge hclk);
    check({7'h0, analog_select_bit}, 32'h100, "analog bit out");
    check({31'h0, periph_in[20]}, 32'h0, "analog pin masked");
    // Serial transmit on pin C6; an input selection write must not disturb it.
    src_cmd <= 24'h200;
    bus(1'h1, 12'h258, 32'h09, rd);
    @(posedge hclk);
    check({31'h0, pin_out[22]}, 32'h1, "c6 tx high");
    bus(1'h1, 12'h150, 32'h16, rd);
    @(posedge hclk);
    check({31'h0, pin_out[22]}, 32'h1, "c6 after input write");
    src_cmd <= 24'h0;
    repeat (2) @(posedge hclk);
    check({31'h0, pin_out[22]}, 32'h0, "c6 tx low");
    // Latch drives code 0 pins; a byte write is ignored; an unmapped place reads 0.
    bus(1'h1, pin_router_pkg::ADDR_LATCH, 32'h1, rd);
    bus(1'h1, pin_router_pkg::ADDR_LATCH, 32'h0, rd, 3'h0);
    bus(1'h0, pin_router_pkg::ADDR_LATCH, 32'h0, rd);
    check(rd, 32'h1, "latch after byte write");
    check({31'h0, pin_out[0]}, 32'h1, "latch pin");
    // A source code past the last source falls back to the latch.
    bus(1'h1, 12'h200, 32'h1F, rd);
    @(posedge hclk);
    check({31'h0, pin_out[0]}, 32'h1, "spare source code");
    bus(1'h1, 12'h0FC, 32'hFFFFFFFF, rd);
    bus(1'h0, 12'h0FC, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    // Reset in mid-run brings back every default.
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    check({7'h0, pin_out}, 32'h0, "pins in reset");
    check({2'h0, periph_in}, 32'h0, "inputs in reset");
    check({7'h0, analog_select_bit}, {7'h0, pin_router_pkg::ANALOG_RESET}, "analog in reset");
    hresetn <= 1'h1;
    for (int i = 0; i < 30; i++) begin
      bus(1'h0, 12'h100 + 12'(i * 4), 32'h0, rd);
      check(rd, {26'h0, pin_router_pkg::IN_SEL_RESET[i]}, "select default");
    end
    bus(1'h0, pin_router_pkg::ADDR_ANALOG, 32'h0, rd);
    check(rd, {7'h0, pin_router_pkg::ANALOG_RESET}, "analog default");
    report_and_stop();
  end
endmodule : peripheral_input_pin_router_tb
